// File: hw/gdds_pkg.sv
package gdds_pkg;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } gdds_apb_s;

  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] c;
    logic [7:0] d;
  } gdds_pins_s;

  typedef struct packed {
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] c;
    logic [15:0] d;
  } gdds_drv_s;

  localparam logic [7:0] GDDS_OFS_PORT_DATA = 8'h00;
  localparam logic [7:0] GDDS_OFS_PORT_DIR = 8'h04;
  localparam logic [7:0] GDDS_PORT_STRIDE = 8'h08;
  localparam logic [7:0] GDDS_OFS_DRV0 = 8'h20;
  localparam logic [7:0] GDDS_OFS_DRV1 = 8'h24;
  localparam logic [7:0] GDDS_OFS_WAKE = 8'h28;
  localparam logic [7:0] GDDS_OFS_PULL = 8'h2c;
  localparam logic [7:0] GDDS_OFS_ANALOG = 8'h30;
  localparam logic [7:0] GDDS_OFS_ADC = 8'h34;
  localparam logic [7:0] GDDS_OFS_BITOP = 8'h38;
  localparam logic [7:0] GDDS_OFS_STAT = 8'h3c;
  localparam logic [7:0] GDDS_OFS_IRQ_EN = 8'h40;
  localparam logic [7:0] GDDS_OFS_IRQ_CLR = 8'h44;

  localparam logic [7:0] GDDS_DATA_RST = 8'hff;
  localparam logic [7:0] GDDS_DIR_RST = 8'hff;
  localparam logic [7:0] GDDS_DRV0_RST = 8'h55;
  localparam logic [7:0] GDDS_DRV1_RST = 8'h15;
  localparam logic [7:0] GDDS_DRV1_MASK = 8'h3f;
  localparam logic [7:0] GDDS_WAKE_RST = 8'h00;
  localparam logic [7:0] GDDS_PULL_RST = 8'h00;
  localparam logic [7:0] GDDS_ANALOG_RST = 8'hff;
  localparam logic GDDS_ADC_RST = 1'b0;

  localparam int GDDS_DRV_A_LO = 0;
  localparam int GDDS_DRV_A_HI = 2;
  localparam int GDDS_DRV_B_LO = 4;
  localparam int GDDS_DRV_B_HI = 6;
  localparam int GDDS_DRV_C_LO = 0;
  localparam int GDDS_DRV_C_HI = 2;
  localparam int GDDS_DRV_D = 4;
  localparam int GDDS_SPLIT = 4;
  localparam int GDDS_W_A = 8;
  localparam int GDDS_W_B = 7;
  localparam int GDDS_W_C = 7;
  localparam int GDDS_W_D = 4;

  localparam int GDDS_BITOP_SEL_LSB = 0;
  localparam int GDDS_BITOP_BIT_LSB = 4;
  localparam int GDDS_BITOP_SET_POS = 8;

  localparam int GDDS_EV_WAKE = 0;
  localparam int GDDS_EV_BITOP = 1;
  localparam int GDDS_NUM_EV = 2;

endpackage

// File: hw/gdds_sync.sv
`timescale 1ns/10ps
module gdds_sync #(
  parameter int W = 8
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule

// File: hw/gdds_port.sv
`timescale 1ns/10ps
module gdds_port #(
  parameter int W = 8,
  parameter int SPLIT = 4
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic data_we_in,
  input wire logic dir_we_in,
  input wire logic [7:0] wdata_in,
  input wire logic [7:0] pin_sync_in,
  input wire logic [1:0] drv_lo_in,
  input wire logic [1:0] drv_hi_in,
  output logic [7:0] data_rd_out,
  output logic [7:0] dir_out,
  output logic [7:0] pad_out,
  output logic [7:0] pad_oe_out,
  output logic [15:0] drive_out
);
  import gdds_pkg::*;

  localparam logic [7:0] MASK = 8'((9'h001 << W) - 9'h001);

  logic [7:0] data_q;
  logic [7:0] data_d;
  logic [7:0] dir_q;
  logic [7:0] dir_d;
  logic [7:0] oe_q;
  logic [7:0] oe_d;
  logic [15:0] drv_q;
  logic [15:0] drv_d;

  always_comb
  begin
    data_d = data_q;
    dir_d = dir_q;
    if (data_we_in)
      data_d = wdata_in & MASK;
    if (dir_we_in)
      dir_d = wdata_in & MASK;
    oe_d = ~dir_d & MASK;
    for (int i = 0; i < 8; i++)
    begin
      if (!oe_d[i])
        drv_d[2*i +: 2] = 2'h0;
      else if (i < SPLIT)
        drv_d[2*i +: 2] = drv_lo_in;
      else
        drv_d[2*i +: 2] = drv_hi_in;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      data_q <= GDDS_DATA_RST & MASK;
      dir_q <= GDDS_DIR_RST & MASK;
      oe_q <= 8'h00;
      drv_q <= 16'h0000;
    end
    else
    begin
      data_q <= data_d;
      dir_q <= dir_d;
      oe_q <= oe_d;
      drv_q <= drv_d;
    end
  end

  // Output pins show the latch, input pins the synchronised level
  assign data_rd_out = ((data_q & ~dir_q) | (pin_sync_in & dir_q)) & MASK;
  assign dir_out = dir_q;
  assign pad_out = data_q;
  assign pad_oe_out = oe_q;
  assign drive_out = drv_q;
endmodule

// File: hw/gdds_top.sv
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/10ps
// Overview of operation
// - Port D direction bits 3..0: 1 input, 0 output; bits 7..4 read zero.
// - Each drive field is two bits: 00 minimum up to 11 maximum level.
// - Drive selection acts only while a pin is an output.
// - First drive register bits 7..6 port B pins 6..4, bits 5..4 pins 3..0.
// - First drive register bits 3..2 port A pins 7..4, bits 1..0 pins 3..0.
// - Second drive register bits 3..2 port C 6..4, 1..0 pins 3..0.
// - Second drive register bits 5..4 drive all port D pins; 7..6 zero.
// - Reset sets all implemented port data and direction bits to one, the unimplemented ones to zero.
// - A pin turned to output unwritten drives the reset latch value, high.
// - Bit set or clear reads the whole port, changes one bit, writes back.
// - After reset converter-shared pins are analog and the converter is off.
// - An enabled analog channel removes the pin's pull-high.
// - In sleep a falling edge on a selected port A pin wakes the device.
// - One wake enable per port A pin, cleared at reset.
// - Reading an output pin returns the data latch.
module gdds_top (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire gdds_pkg::gdds_apb_s apb_in,
  output logic apb_pready_out,
  output logic [31:0] apb_prdata_out,
  output logic apb_pslverr_out,
  input wire gdds_pkg::gdds_pins_s pin_in,
  output gdds_pkg::gdds_pins_s pad_out_out,
  output gdds_pkg::gdds_pins_s pad_oe_out,
  output gdds_pkg::gdds_drv_s drive_out,
  output logic [7:0] pull_en_out,
  output logic [7:0] analog_en_out,
  output logic adc_power_out,
  input wire logic sleep_in,
  output logic wake_out,
  output logic irq_out
);
  import gdds_pkg::*;

  gdds_pins_s pin_s;
  logic [3:0][7:0] data_rd;
  logic [3:0][7:0] dir_v;
  logic [3:0][7:0] pad_v;
  logic [3:0][7:0] oe_v;
  logic [3:0][15:0] drv_v;
  logic [3:0] data_we;
  logic [3:0] dir_we;
  logic [7:0] port_wdata;

  logic acc;
  logic wr;
  logic hit;
  logic [31:0] rdata;
  logic bitop;
  logic [2:0] bsel;
  logic [2:0] bpos;
  logic [7:0] bcur;
  logic [7:0] bnew;

  logic pready_q;
  logic pready_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pslverr_q;
  logic pslverr_d;

  logic [7:0] drv0_q;
  logic [7:0] drv0_d;
  logic [7:0] drv1_q;
  logic [7:0] drv1_d;
  logic [7:0] wake_en_q;
  logic [7:0] wake_en_d;
  logic [7:0] pull_q;
  logic [7:0] pull_d;
  logic [7:0] analog_q;
  logic [7:0] analog_d;
  logic adc_q;
  logic adc_d;
  logic [7:0] pull_en_q;
  logic [7:0] pull_en_d;

  logic [7:0] prev_a_q;
  logic [7:0] prev_a_d;
  logic wake_q;
  logic wake_d;

  logic [GDDS_NUM_EV-1:0] ev;
  logic [GDDS_NUM_EV-1:0] clr;
  logic [GDDS_NUM_EV-1:0] stat_q;
  logic [GDDS_NUM_EV-1:0] stat_d;
  logic [GDDS_NUM_EV-1:0] irq_en_q;
  logic [GDDS_NUM_EV-1:0] irq_en_d;
  logic irq_q;
  logic irq_d;

  // Pin levels cross into the clock domain here
  gdds_sync #(
    .W(32)
  ) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in(pin_in),
    .sync_out(pin_s)
  );

  gdds_port #(
    .W(GDDS_W_A),
    .SPLIT(GDDS_SPLIT)
  ) u_port_a (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .data_we_in(data_we[0]),
    .dir_we_in(dir_we[0]),
    .wdata_in(port_wdata),
    .pin_sync_in(pin_s.a),
    .drv_lo_in(drv0_q[GDDS_DRV_A_LO +: 2]),
    .drv_hi_in(drv0_q[GDDS_DRV_A_HI +: 2]),
    .data_rd_out(data_rd[0]),
    .dir_out(dir_v[0]),
    .pad_out(pad_v[0]),
    .pad_oe_out(oe_v[0]),
    .drive_out(drv_v[0])
  );

  gdds_port #(
    .W(GDDS_W_B),
    .SPLIT(GDDS_SPLIT)
  ) u_port_b (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .data_we_in(data_we[1]),
    .dir_we_in(dir_we[1]),
    .wdata_in(port_wdata),
    .pin_sync_in(pin_s.b),
    .drv_lo_in(drv0_q[GDDS_DRV_B_LO +: 2]),
    .drv_hi_in(drv0_q[GDDS_DRV_B_HI +: 2]),
    .data_rd_out(data_rd[1]),
    .dir_out(dir_v[1]),
    .pad_out(pad_v[1]),
    .pad_oe_out(oe_v[1]),
    .drive_out(drv_v[1])
  );

  gdds_port #(
    .W(GDDS_W_C),
    .SPLIT(GDDS_SPLIT)
  ) u_port_c (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .data_we_in(data_we[2]),
    .dir_we_in(dir_we[2]),
    .wdata_in(port_wdata),
    .pin_sync_in(pin_s.c),
    .drv_lo_in(drv1_q[GDDS_DRV_C_LO +: 2]),
    .drv_hi_in(drv1_q[GDDS_DRV_C_HI +: 2]),
    .data_rd_out(data_rd[2]),
    .dir_out(dir_v[2]),
    .pad_out(pad_v[2]),
    .pad_oe_out(oe_v[2]),
    .drive_out(drv_v[2])
  );

  gdds_port #(
    .W(GDDS_W_D),
    .SPLIT(GDDS_SPLIT)
  ) u_port_d (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .data_we_in(data_we[3]),
    .dir_we_in(dir_we[3]),
    .wdata_in(port_wdata),
    .pin_sync_in(pin_s.d),
    .drv_lo_in(drv1_q[GDDS_DRV_D +: 2]),
    .drv_hi_in(drv1_q[GDDS_DRV_D +: 2]),
    .data_rd_out(data_rd[3]),
    .dir_out(dir_v[3]),
    .pad_out(pad_v[3]),
    .pad_oe_out(oe_v[3]),
    .drive_out(drv_v[3])
  );

  // Bus decode and single-bit read-modify-write
  always_comb
  begin
    acc = apb_in.psel & apb_in.penable;
    wr = acc & apb_in.pwrite & pready_q;
    bsel = apb_in.pwdata[GDDS_BITOP_SEL_LSB +: 3];
    bpos = apb_in.pwdata[GDDS_BITOP_BIT_LSB +: 3];
    bcur = bsel[0] ? dir_v[bsel[2:1]] : data_rd[bsel[2:1]];
    bnew = bcur;
    bnew[bpos] = apb_in.pwdata[GDDS_BITOP_SET_POS];
    bitop = wr & (apb_in.paddr == GDDS_OFS_BITOP);
    port_wdata = bitop ? bnew : apb_in.pwdata[7:0];
    for (int p = 0; p < 4; p++)
    begin
      data_we[p] = (wr & (apb_in.paddr == GDDS_OFS_PORT_DATA
                   + 8'(p) * GDDS_PORT_STRIDE))
                   | (bitop & (bsel == {2'(p), 1'b0}));
      dir_we[p] = (wr & (apb_in.paddr == GDDS_OFS_PORT_DIR
                  + 8'(p) * GDDS_PORT_STRIDE))
                  | (bitop & (bsel == {2'(p), 1'b1}));
    end
  end

  // Read multiplexer
  always_comb
  begin
    rdata = 32'h0000_0000;
    hit = 1'b1;
    case (apb_in.paddr)
      GDDS_OFS_DRV0: rdata[7:0] = drv0_q;
      GDDS_OFS_DRV1: rdata[7:0] = drv1_q & GDDS_DRV1_MASK;
      GDDS_OFS_WAKE: rdata[7:0] = wake_en_q;
      GDDS_OFS_PULL: rdata[7:0] = pull_q;
      GDDS_OFS_ANALOG: rdata[7:0] = analog_q;
      GDDS_OFS_ADC: rdata[0] = adc_q;
      GDDS_OFS_BITOP: rdata = 32'h0000_0000;
      GDDS_OFS_STAT: rdata[GDDS_NUM_EV-1:0] = stat_q;
      GDDS_OFS_IRQ_EN: rdata[GDDS_NUM_EV-1:0] = irq_en_q;
      GDDS_OFS_IRQ_CLR: rdata = 32'h0000_0000;
      default: hit = 1'b0;
    endcase
    for (int p = 0; p < 4; p++)
    begin
      if (apb_in.paddr == GDDS_OFS_PORT_DATA + 8'(p) * GDDS_PORT_STRIDE)
      begin
        rdata[7:0] = data_rd[p];
        hit = 1'b1;
      end
      if (apb_in.paddr == GDDS_OFS_PORT_DIR + 8'(p) * GDDS_PORT_STRIDE)
      begin
        rdata[7:0] = dir_v[p];
        hit = 1'b1;
      end
    end
  end

  // Bus answer one cycle into the access phase
  always_comb
  begin
    pready_d = acc & ~pready_q;
    prdata_d = pready_d ? rdata : prdata_q;
    pslverr_d = pready_d & ~hit;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q <= pready_d;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Configuration registers
  always_comb
  begin
    drv0_d = drv0_q;
    drv1_d = drv1_q;
    wake_en_d = wake_en_q;
    pull_d = pull_q;
    analog_d = analog_q;
    adc_d = adc_q;
    irq_en_d = irq_en_q;
    clr = '0;
    if (wr)
    begin
      unique case (apb_in.paddr)
        GDDS_OFS_DRV0: drv0_d = apb_in.pwdata[7:0];
        GDDS_OFS_DRV1: drv1_d = apb_in.pwdata[7:0] & GDDS_DRV1_MASK;
        GDDS_OFS_WAKE: wake_en_d = apb_in.pwdata[7:0];
        GDDS_OFS_PULL: pull_d = apb_in.pwdata[7:0];
        GDDS_OFS_ANALOG: analog_d = apb_in.pwdata[7:0];
        GDDS_OFS_ADC: adc_d = apb_in.pwdata[0];
        GDDS_OFS_IRQ_EN: irq_en_d = apb_in.pwdata[GDDS_NUM_EV-1:0];
        GDDS_OFS_IRQ_CLR: clr = apb_in.pwdata[GDDS_NUM_EV-1:0];
        default: clr = '0;
      endcase
    end
    // Pull-high only on port A inputs with no analog channel
    pull_en_d = pull_q & dir_v[0] & ~analog_q;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      drv0_q <= GDDS_DRV0_RST;
      drv1_q <= GDDS_DRV1_RST;
      wake_en_q <= GDDS_WAKE_RST;
      pull_q <= GDDS_PULL_RST;
      analog_q <= GDDS_ANALOG_RST;
      adc_q <= GDDS_ADC_RST;
      irq_en_q <= '0;
      pull_en_q <= 8'h00;
    end
    else
    begin
      drv0_q <= drv0_d;
      drv1_q <= drv1_d;
      wake_en_q <= wake_en_d;
      pull_q <= pull_d;
      analog_q <= analog_d;
      adc_q <= adc_d;
      irq_en_q <= irq_en_d;
      pull_en_q <= pull_en_d;
    end
  end

  // Falling edge wake-up on port A
  always_comb
  begin
    prev_a_d = pin_s.a;
    wake_d = sleep_in & (|(prev_a_q & ~pin_s.a & wake_en_q));
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      prev_a_q <= 8'h00;
      wake_q <= 1'b0;
    end
    else
    begin
      prev_a_q <= prev_a_d;
      wake_q <= wake_d;
    end
  end

  // Sticky status, a new event wins over a clear
  always_comb
  begin
    ev = '0;
    ev[GDDS_EV_WAKE] = wake_d;
    ev[GDDS_EV_BITOP] = bitop;
    stat_d = (stat_q & ~clr) | ev;
    irq_d = |(stat_d & irq_en_d);
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      stat_q <= '0;
      irq_q <= 1'b0;
    end
    else
    begin
      stat_q <= stat_d;
      irq_q <= irq_d;
    end
  end

  assign apb_pready_out = pready_q;
  assign apb_prdata_out = prdata_q;
  assign apb_pslverr_out = pslverr_q;
  assign pad_out_out = {pad_v[0], pad_v[1], pad_v[2], pad_v[3]};
  assign pad_oe_out = {oe_v[0], oe_v[1], oe_v[2], oe_v[3]};
  assign drive_out = {drv_v[0], drv_v[1], drv_v[2], drv_v[3]};
  assign pull_en_out = pull_en_q;
  assign analog_en_out = analog_q;
  assign adc_power_out = adc_q;
  assign wake_out = wake_q;
  assign irq_out = irq_q;
endmodule

// File: dv/gdds_pins_model.sv
`timescale 1ns/10ps
module gdds_pins_model
  import gdds_pkg::*;
(
  input wire gdds_pkg::gdds_pins_s pad_in,
  input wire gdds_pkg::gdds_pins_s oe_in,
  input wire gdds_pkg::gdds_pins_s ext_in,
  input wire logic short_in,
  output gdds_pkg::gdds_pins_s pin_out
);
  // Driven pins show the pad level; a commanded short forces the outside level
  assign pin_out = short_in ? ext_in : (oe_in & pad_in) | (~oe_in & ext_in);
endmodule

// File: dv/gdds_checker.sv
`timescale 1ns/10ps
module gdds_checker
  import gdds_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire gdds_pkg::gdds_apb_s apb_in,
  input wire logic apb_pready_out,
  input wire gdds_pkg::gdds_pins_s pin_in,
  input wire gdds_pkg::gdds_pins_s pad_oe_out,
  input wire gdds_pkg::gdds_drv_s drive_out,
  input wire logic [7:0] pull_en_out,
  input wire logic [7:0] analog_en_out,
  input wire logic adc_power_out,
  input wire logic sleep_in,
  input wire logic wake_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  function automatic logic [15:0] sp(input logic [7:0] o);
    for (int i = 0; i < 8; i++)
      sp[2*i +: 2] = {2{o[i]}};
  endfunction
  sequence s_first_access;
    apb_in.psel && apb_in.penable && !$past(apb_in.penable);
  endsequence
  sequence s_answer;
    !apb_pready_out ##1 apb_pready_out;
  endsequence
  property p_ready_time;
    s_first_access |-> s_answer;
  endproperty
  a_ready_time: assert property (p_ready_time)
    else $error("answer not one cycle after access");
  property p_ready_pulse;
    apb_pready_out |=> !apb_pready_out;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready longer than one cycle");
  property p_reset;
    $fell(rst_in) |-> pad_oe_out == 32'h0 && drive_out == 64'h0
      && analog_en_out == 8'hff && !adc_power_out;
  endproperty
  a_reset: assert property (p_reset)
    else $error("wrong state after reset");
  property p_d_upper;
    pad_oe_out.d[7:4] == 4'h0 && drive_out.d[15:8] == 8'h00;
  endproperty
  a_d_upper: assert property (p_d_upper)
    else $error("unimplemented port d pin active");
  property p_drv_input;
    (drive_out & ~{sp(pad_oe_out.a), sp(pad_oe_out.b), sp(pad_oe_out.c),
      sp(pad_oe_out.d)}) == 64'h0;
  endproperty
  a_drv_input: assert property (p_drv_input)
    else $error("drive level on input pin");
  property p_d_shared;
    &pad_oe_out.d[3:0] |-> drive_out.d[7:0] == {4{drive_out.d[1:0]}};
  endproperty
  a_d_shared: assert property (p_d_shared)
    else $error("port d pins differ in level");
  property p_pull;
    (pull_en_out & $past(analog_en_out)) == 8'h00;
  endproperty
  a_pull: assert property (p_pull)
    else $error("pull-high on analog pin");
  property p_wake;
    wake_out |-> $past(sleep_in)
      && ($past(pin_in.a, 4) & ~$past(pin_in.a, 3)) != 8'h00;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake without falling edge in sleep");
endmodule

bind gdds_top gdds_checker gdds_checker_inst (.clk_in, .rst_in, .apb_in,
  .apb_pready_out, .pin_in, .pad_oe_out, .drive_out, .pull_en_out,
  .analog_en_out, .adc_power_out, .sleep_in, .wake_out);

// File: dv/tb_gpio_direction_drive_strength.sv
`timescale 1ns/10ps
module tb_gpio_direction_drive_strength;
  import gdds_pkg::*;
  localparam logic [31:0] MSK = 32'hff7f7f0f;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic sleep_in = 1'b0;
  logic short_q = 1'b0;
  gdds_apb_s apb_in = '0;
  gdds_pins_s ext = 32'h5a3c2e06;
  gdds_pins_s pin_in, pad_out_out, pad_oe_out;
  gdds_drv_s drive_out;
  logic apb_pready_out, apb_pslverr_out, wake_out, irq_out, adc_power_out;
  logic [31:0] apb_prdata_out, rd_q;
  logic [7:0] pull_en_out, analog_en_out, dir;
  logic [1:0] k2;
  logic err_q;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  int wake_cnt = 0;

  always #5 clk_in = ~clk_in;

  gdds_top gdds_top_inst (.clk_in, .rst_in, .apb_in, .apb_pready_out,
    .apb_prdata_out, .apb_pslverr_out, .pin_in, .pad_out_out, .pad_oe_out,
    .drive_out, .pull_en_out, .analog_en_out, .adc_power_out, .sleep_in,
    .wake_out, .irq_out);
  gdds_pins_model gdds_pins_model_inst (.pad_in(pad_out_out),
    .oe_in(pad_oe_out), .ext_in(ext), .short_in(short_q), .pin_out(pin_in));

  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge clk_in)
  begin
    cyc++;
    if (wake_out === 1'b1)
      wake_cnt++;
    if (cyc == 3000)
    begin
      bad_count++;
      stop_test();
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    apb_in <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_in);
    apb_in.penable <= 1'b1;
    do
      @(posedge clk_in);
    while (apb_pready_out !== 1'b1);
    rd_q = apb_prdata_out;
    err_q = apb_pslverr_out;
    apb_in <= '0;
    repeat (2) @(posedge clk_in);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd_q, e);
  endtask

  task automatic fall1;
    ext.a[1] <= 1'b0;
    repeat (6) @(posedge clk_in);
    ext.a[1] <= 1'b1;
    repeat (4) @(posedge clk_in);
  endtask

  function automatic logic [15:0] dx(input logic [1:0] lo,
    input logic [1:0] hi, input logic [7:0] d, input int w);
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < w; i++)
      if (!d[i])
        r[2*i +: 2] = (i < 4) ? lo : hi;
    return r;
  endfunction

  initial
  begin
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    for (int p = 0; p < 4; p++)
    begin
      rd(8'(8 * p), {24'h0, ext[31 - 8 * p -: 8]});
      rd(8'(8 * p + 4), {24'h0, MSK[31 - 8 * p -: 8]});
    end
    rd(GDDS_OFS_DRV0, 32'h55);
    rd(GDDS_OFS_DRV1, 32'h15);
    rd(GDDS_OFS_WAKE, 32'h0);
    rd(GDDS_OFS_ANALOG, 32'hff);
    rd(GDDS_OFS_ADC, 32'h0);
    chk(pad_oe_out, 32'h0);
    chk(drive_out, 64'h0);
    chk(pad_out_out, MSK);
    $display("test reset done");
    for (int k = 0; k < 4; k++)
    begin
      k2 = 2'(k);
      dir = 8'hf0 >> (3 - k);
      for (int p = 0; p < 4; p++)
        wr(8'(8 * p + 4), {24'h0, dir});
      wr(GDDS_OFS_DRV0, {24'h0, k2 + 2'd3, k2 + 2'd2, k2 + 2'd1, k2});
      wr(GDDS_OFS_DRV1, {24'h0, 2'b11, k2 + 2'd2, k2 + 2'd1, k2});
      rd(GDDS_OFS_DRV1, {24'h0, 2'b00, k2 + 2'd2, k2 + 2'd1, k2});
      chk(drive_out.a, dx(k2, k2 + 2'd1, dir, 8));
      chk(drive_out.b, dx(k2 + 2'd2, k2 + 2'd3, dir, 7));
      chk(drive_out.c, dx(k2, k2 + 2'd1, dir, 7));
      chk(drive_out.d, dx(k2 + 2'd2, k2 + 2'd2, dir, 4));
      chk(pad_oe_out.d, {4'h0, ~dir[3:0]});
    end
    $display("test drive done");
    chk(pad_out_out.a, 8'hff);
    short_q <= 1'b1;
    repeat (3) @(posedge clk_in);
    rd(8'h00, {24'h0, (ext.a & dir) | ~dir});
    short_q <= 1'b0;
    wr(GDDS_OFS_BITOP, 32'h43);
    rd(8'h0c, 32'h60);
    wr(GDDS_OFS_BITOP, 32'h36);
    rd(GDDS_OFS_STAT, 32'h2);
    chk(pad_out_out.d, 8'h07);
    $display("test latch done");
    wr(8'h04, 32'hff);
    wr(GDDS_OFS_WAKE, 32'h2);
    wr(GDDS_OFS_IRQ_EN, 32'h1);
    wr(GDDS_OFS_IRQ_CLR, 32'h2);
    sleep_in <= 1'b1;
    ext.a[3] <= 1'b0;
    repeat (6) @(posedge clk_in);
    chk(wake_cnt, 0);
    fall1();
    chk(wake_cnt, 1);
    chk(irq_out, 1'b1);
    rd(GDDS_OFS_STAT, 32'h1);
    wr(GDDS_OFS_IRQ_CLR, 32'h1);
    chk(irq_out, 1'b0);
    wr(GDDS_OFS_IRQ_EN, 32'h0);
    fall1();
    chk(irq_out, 1'b0);
    sleep_in <= 1'b0;
    fall1();
    chk(wake_cnt, 2);
    $display("test wake done");
    wr(GDDS_OFS_PULL, 32'hff);
    wr(GDDS_OFS_ANALOG, 32'h0f);
    chk(analog_en_out, 8'h0f);
    chk(pull_en_out, 8'hf0);
    wr(GDDS_OFS_ADC, 32'h1);
    chk(adc_power_out, 1'b1);
    rd(8'h80, 32'h0);
    chk(err_q, 1'b1);
    $display("test analog done");
    stop_test();
  end
endmodule
